// ==== verilog/sxt_uart.sv ====
// asynchronous serial transceiver with transmit and receive buffers
`timescale 1ns/10ps
module sxt_uart (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// configuration
	input wire logic [15:0] serial_mode_i,
	input wire logic [15:0] baud_divisor_i,
	input wire logic tx_gate_i,
	input wire logic tx_irq_mode_i,
	input wire logic tx_break_send_i,
	input wire logic addr_detect_on_i,
	input wire logic [1:0] rx_irq_mode_i,
	// transmit data
	input wire logic [sxt_pkg::CHAR_W-1:0] tx_data_i,
	input wire logic tx_write_i,
	// receive data and status
	input wire logic rx_read_i,
	input wire logic overrun_clr_i,
	output logic [sxt_pkg::CHAR_W-1:0] rx_data_o,
	output logic [15:0] serial_status_o,
	output logic tx_irq_o,
	output logic rx_irq_o,
	// serial link
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o
);
	import sxt_pkg::*;

	typedef enum logic [2:0] {T_IDLE, T_WAIT, T_START, T_DATA, T_PAR, T_STOP} sxt_tx_state_t;
	typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP, R_BRK} sxt_rx_state_t;

	// ****************************************
	// configuration
	// ****************************************
	logic module_on_q;
	logic [1:0] fmt_q;
	logic stop2_q;
	logic loop_q;
	logic gate_q;
	logic gate_rise;
	logic par_on;
	logic [3:0] last_bit;

	// settings take effect only while the module is on
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			module_on_q <= 1'h0;
			fmt_q <= RESET_FMT;
			stop2_q <= RESET_STOP;
			loop_q <= 1'h0;
			gate_q <= 1'h0;
		end
		else
		begin
			module_on_q <= serial_mode_i[MD_ON];
			fmt_q <= serial_mode_i[MD_FMT_HI:MD_FMT_LO];
			stop2_q <= serial_mode_i[MD_STOP];
			loop_q <= serial_mode_i[MD_LOOP];
			gate_q <= tx_gate_i && serial_mode_i[MD_ON];
		end
	end

	assign gate_rise = tx_gate_i && module_on_q && !gate_q;
	assign par_on = (fmt_q == FMT_8E) || (fmt_q == FMT_8O);
	assign last_bit = (fmt_q == FMT_9N) ? 4'h8 : 4'h7;

	// ****************************************
	// baud clock and buffers
	// ****************************************
	logic tick;
	logic tx_in_ready;
	logic tx_out_valid;
	logic [CHAR_W-1:0] tx_head;
	logic [2:0] tx_cnt;
	logic tx_pop;
	logic rx_in_ready;
	logic rx_out_valid;
	logic [RX_W-1:0] rx_head;
	logic [RX_W-1:0] rx_word;
	logic [4:0] rx_cnt;
	logic rx_fin;

	// a cleared baud counter on enable makes a freshly gated word start at once
	sxt_baud u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(!module_on_q || gate_rise),
		.div_i(baud_divisor_i),
		.tick_o(tick)
	);

	// transmit buffer; the shift register is a fifth stage
	sxt_fifo #(.W(CHAR_W), .D(TX_DEPTH)) u_tx_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flush_i(!module_on_q),
		.in_valid_i(tx_write_i && module_on_q),
		.in_data_i(tx_data_i),
		.in_ready_o(tx_in_ready),
		.out_ready_i(tx_pop),
		.out_valid_o(tx_out_valid),
		.out_data_o(tx_head),
		.count_o(tx_cnt)
	);

	// receive buffer; a full buffer turns new characters into an overrun
	sxt_fifo #(.W(RX_W), .D(RX_DEPTH)) u_rx_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flush_i(!module_on_q),
		.in_valid_i(rx_fin),
		.in_data_i(rx_word),
		.in_ready_o(rx_in_ready),
		.out_ready_i(rx_read_i && module_on_q),
		.out_valid_o(rx_out_valid),
		.out_data_o(rx_head),
		.count_o(rx_cnt)
	);

	// ****************************************
	// transmitter
	// ****************************************
	sxt_tx_state_t tx_st_q;
	logic [CHAR_W-1:0] tx_sh_q;
	logic [3:0] tx_tick_q;
	logic [3:0] tx_bit_q;
	logic tx_par_q;
	logic tx_stp_q;
	logic tx_out_q;
	logic tx_bit_end;
	logic tx_done;

	assign tx_pop = (tx_st_q == T_IDLE) && gate_q && tx_out_valid && !tx_break_send_i;
	assign tx_bit_end = tick && (tx_tick_q == LAST_TICK);
	assign tx_done = (tx_st_q == T_STOP) && tx_bit_end && (!stop2_q || tx_stp_q);

	// shift engine; disabling drops the character in flight
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !module_on_q)
		begin
			tx_st_q <= T_IDLE;
			tx_sh_q <= '0;
			tx_tick_q <= 4'h0;
			tx_bit_q <= 4'h0;
			tx_par_q <= 1'h0;
			tx_stp_q <= 1'h0;
			tx_out_q <= 1'h1;
		end
		else
		begin
			unique case (tx_st_q)
				T_IDLE:
				begin
					tx_out_q <= !(tx_break_send_i && gate_q);
					if (tx_pop)
					begin
						tx_sh_q <= tx_head;
						tx_par_q <= (^tx_head[7:0]) ^ (fmt_q == FMT_8O);
						tx_st_q <= T_WAIT;
					end
				end
				T_WAIT:
				begin
					// output starts on the next baud tick
					if (tick)
					begin
						tx_out_q <= 1'h0;
						tx_tick_q <= 4'h0;
						tx_st_q <= T_START;
					end
				end
				T_START, T_DATA, T_PAR, T_STOP:
				begin
					if (tick)
						tx_tick_q <= 4'(tx_tick_q + 4'h1);
					if (tx_bit_end)
					begin
						if (tx_st_q == T_START)
						begin
							tx_st_q <= T_DATA;
							tx_bit_q <= 4'h0;
							tx_out_q <= tx_sh_q[0];
						end
						else if (tx_st_q == T_DATA && tx_bit_q != last_bit)
						begin
							tx_bit_q <= 4'(tx_bit_q + 4'h1);
							tx_sh_q <= tx_sh_q >> 1;
							tx_out_q <= tx_sh_q[1];
						end
						else if (tx_st_q == T_DATA && par_on)
						begin
							tx_st_q <= T_PAR;
							tx_out_q <= tx_par_q;
						end
						else if (tx_st_q != T_STOP)
						begin
							tx_st_q <= T_STOP;
							tx_stp_q <= 1'h0;
							tx_out_q <= 1'h1;
						end
						else if (stop2_q && !tx_stp_q)
							tx_stp_q <= 1'h1;
						else
							tx_st_q <= T_IDLE;
					end
				end
			endcase
		end
	end

	// transmit interrupt: buffer slot freed, or everything sent
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_irq_o <= 1'h0;
		else
			tx_irq_o <= module_on_q && (tx_irq_mode_i ? (tx_done && !tx_out_valid) : tx_pop);
	end

	// ****************************************
	// receiver
	// ****************************************
	sxt_rx_state_t rx_st_q;
	logic rx_line;
	logic [CHAR_W-1:0] rx_sh_q;
	logic [3:0] rx_tick_q;
	logic [3:0] rx_bit_q;
	logic rx_parity_fault_q;
	logic rx_framing_fault_q;
	logic rx_stp_q;
	logic rx_quiet_q;
	logic rx_smp;
	logic rx_framing_fault_now;
	logic overrun_fault_q;

	assign rx_line = loop_q ? tx_out_q : serial_in_pin_i;
	assign rx_smp = tick && (rx_tick_q == LAST_TICK);
	assign rx_framing_fault_now = rx_framing_fault_q || !rx_line;
	assign rx_fin = (rx_st_q == R_STOP) && rx_smp && (!stop2_q || rx_stp_q);
	assign rx_word = {rx_framing_fault_now, rx_parity_fault_q, rx_sh_q};

	// bit sampler running at sixteen ticks per bit
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !module_on_q)
		begin
			rx_st_q <= R_IDLE;
			rx_sh_q <= '0;
			rx_tick_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_parity_fault_q <= 1'h0;
			rx_framing_fault_q <= 1'h0;
			rx_stp_q <= 1'h0;
			rx_quiet_q <= 1'h1;
		end
		else
		begin
			if (tick)
				rx_tick_q <= 4'(rx_tick_q + 4'h1);
			unique case (rx_st_q)
				R_IDLE:
				begin
					if (tick && !rx_line)
					begin
						rx_st_q <= R_START;
						rx_tick_q <= 4'h0;
						rx_quiet_q <= 1'h0;
						rx_sh_q <= '0;
						rx_parity_fault_q <= 1'h0;
						rx_framing_fault_q <= 1'h0;
						rx_stp_q <= 1'h0;
					end
				end
				R_START:
				begin
					// a glitch shorter than half a bit is not a start
					if (tick && rx_tick_q == MID_TICK)
					begin
						rx_tick_q <= 4'h0;
						rx_bit_q <= 4'h0;
						rx_st_q <= rx_line ? R_IDLE : R_DATA;
						rx_quiet_q <= rx_line;
					end
				end
				R_DATA:
				begin
					if (rx_smp)
					begin
						rx_sh_q[rx_bit_q] <= rx_line;
						rx_bit_q <= 4'(rx_bit_q + 4'h1);
						if (rx_bit_q == last_bit)
							rx_st_q <= par_on ? R_PAR : R_STOP;
					end
				end
				R_PAR:
				begin
					if (rx_smp)
					begin
						rx_parity_fault_q <= rx_line ^ (^rx_sh_q[7:0]) ^ (fmt_q == FMT_8O);
						rx_st_q <= R_STOP;
					end
				end
				R_STOP:
				begin
					if (rx_smp)
					begin
						rx_framing_fault_q <= rx_framing_fault_now;
						rx_stp_q <= 1'h1;
						if (rx_fin)
						begin
							rx_quiet_q <= 1'h1;
							rx_st_q <= rx_framing_fault_now ? R_BRK : R_IDLE;
						end
					end
				end
				R_BRK:
				begin
					// a low line here is still the break, never a start
					if (tick && rx_line)
						rx_st_q <= R_IDLE;
				end
			endcase
		end
	end

	// overrun flag; a new overrun wins over a clear in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !module_on_q)
			overrun_fault_q <= 1'h0;
		else if (rx_fin && !rx_in_ready)
			overrun_fault_q <= 1'h1;
		else if (overrun_clr_i)
			overrun_fault_q <= 1'h0;
	end

	// receive interrupt; address words interrupt whatever the level mode
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_irq_o <= 1'h0;
		else if (!rx_fin || !rx_in_ready)
			rx_irq_o <= 1'h0;
		else if (addr_detect_on_i && fmt_q == FMT_9N)
			rx_irq_o <= rx_sh_q[8];
		else if (rx_irq_mode_i == 2'h2)
			rx_irq_o <= (rx_cnt >= RX_TQ_LVL);
		else if (rx_irq_mode_i == 2'h3)
			rx_irq_o <= (rx_cnt == RX_FULL_LVL);
		else
			rx_irq_o <= 1'h1;
	end

	// ****************************************
	// status and read data
	// ****************************************
	// parity and framing flags follow the character at the head of the receive buffer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_data_o <= '0;
			serial_status_o <= RESET_STATUS;
		end
		else
		begin
			rx_data_o <= rx_out_valid ? rx_head[CHAR_W-1:0] : '0;
			serial_status_o <= 16'h0000;
			serial_status_o[ST_TXIM] <= tx_irq_mode_i;
			serial_status_o[ST_BRK] <= tx_break_send_i && module_on_q;
			serial_status_o[ST_GATE] <= gate_q;
			serial_status_o[ST_FULL] <= !tx_in_ready && module_on_q;
			serial_status_o[ST_TEMPTY] <= (tx_st_q == T_IDLE);
			serial_status_o[ST_RXIM_HI:ST_RXIM_LO] <= rx_irq_mode_i;
			serial_status_o[ST_ADDR] <= addr_detect_on_i;
			serial_status_o[ST_QUIET] <= rx_quiet_q;
			serial_status_o[ST_PARITY_FAULT] <= rx_out_valid && rx_head[CHAR_W];
			serial_status_o[ST_FRAMING_FAULT] <= rx_out_valid && rx_head[CHAR_W+1];
			serial_status_o[ST_OVERRUN_FAULT] <= overrun_fault_q;
			serial_status_o[ST_AVAIL] <= rx_out_valid;
		end
	end

	assign serial_out_pin_o = tx_out_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_GATE_HOLD: assert property ((tx_st_q == T_IDLE && !gate_q) |=> tx_st_q == T_IDLE)
		else $error("transmitter left idle with gate clear");
	AST_FULL_FLAG: assert property ((tx_cnt == 3'h4) == !tx_in_ready)
		else $error("full flag disagrees with fill level");
	AST_FULL_DROP: assert property ((!tx_in_ready && !tx_pop && module_on_q) |=> tx_cnt == $past(tx_cnt))
		else $error("write into full buffer changed it");
	AST_OFF_CLEAR: assert property (!module_on_q |=> tx_cnt == 3'h0 && rx_cnt == 5'h00 && rx_quiet_q)
		else $error("disable did not clear the module");
	AST_START_EDGE: assert property ((tx_st_q == T_WAIT && tick) |=> !tx_out_q ##1 !tx_out_q)
		else $error("start bit not sent on baud tick");
	AST_REST_HIGH: assert property ((tx_st_q == T_IDLE && !tx_break_send_i) |=> tx_out_q)
		else $error("idle output not high");
	AST_QUIET_LOW: assert property (rx_st_q inside {R_DATA, R_PAR, R_STOP} |-> !rx_quiet_q)
		else $error("quiet flag high during a character");
	AST_BRK_WAIT: assert property ((rx_st_q == R_BRK && !rx_line && module_on_q) |=> rx_st_q == R_BRK)
		else $error("break line taken as start");
	AST_BRK_CHAR: assert property ((rx_fin && rx_sh_q == '0 && !rx_line) |=> rx_st_q == R_BRK && rx_quiet_q)
		else $error("break character mishandled");
	AST_NO_PARITY: assert property ((rx_fin && !par_on) |-> !rx_word[CHAR_W])
		else $error("parity flag outside parity format");

	COV_TWO_STOP: cover property (tx_done && stop2_q);
	COV_BREAK: cover property (rx_st_q == R_BRK);
	COV_ADDR_IRQ: cover property (rx_irq_o && addr_detect_on_i);
endmodule

// ==== verilog/sxt_pkg.sv ====
// shared constants for the asynchronous serial transceiver
package sxt_pkg;
	// ****************************************
	// character formats
	// ****************************************
	localparam logic [1:0] FMT_8N = 2'h0;
	localparam logic [1:0] FMT_8E = 2'h1;
	localparam logic [1:0] FMT_8O = 2'h2;
	localparam logic [1:0] FMT_9N = 2'h3;
	localparam logic [1:0] RESET_FMT = FMT_8N;
	localparam logic RESET_STOP = 1'h0;
	// status after reset: receiver quiet and shifter empty
	localparam logic [15:0] RESET_STATUS = 16'h0110;

	// ****************************************
	// mode word bit positions
	// ****************************************
	localparam int MD_ON = 15;
	localparam int MD_LOOP = 6;
	localparam int MD_FMT_HI = 2;
	localparam int MD_FMT_LO = 1;
	localparam int MD_STOP = 0;

	// ****************************************
	// status word bit positions
	// ****************************************
	localparam int ST_TXIM = 15;
	localparam int ST_BRK = 11;
	localparam int ST_GATE = 10;
	localparam int ST_FULL = 9;
	localparam int ST_TEMPTY = 8;
	localparam int ST_RXIM_HI = 7;
	localparam int ST_RXIM_LO = 6;
	localparam int ST_ADDR = 5;
	localparam int ST_QUIET = 4;
	localparam int ST_PARITY_FAULT = 3;
	localparam int ST_FRAMING_FAULT = 2;
	localparam int ST_OVERRUN_FAULT = 1;
	localparam int ST_AVAIL = 0;

	// ****************************************
	// timing and sizes
	// ****************************************
	localparam logic [3:0] MID_TICK = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hF;
	localparam int CHAR_W = 9;
	localparam int RX_W = 11;
	localparam int TX_DEPTH = 4;
	localparam int RX_DEPTH = 16;
	localparam logic [4:0] RX_TQ_LVL = 5'h0B;
	localparam logic [4:0] RX_FULL_LVL = 5'h0F;
endpackage

// ==== verilog/sxt_fifo.sv ====
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/10ps
module sxt_fifo #(
	parameter int W = 9,
	parameter int D = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	// filling side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// draining side
	input wire logic out_ready_i,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	output logic [$clog2(D+1)-1:0] count_o
);
	localparam int PW = $clog2(D);
	localparam int CW = $clog2(D+1);

	logic [W-1:0] mem [D];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	logic wr;
	logic rd;

	// a write to a full buffer is refused, nothing inside moves
	assign in_ready_o = (count_o != CW'(D));
	assign out_valid_o = (count_o != '0);
	assign out_data_o = mem[rp_q];
	assign wr = in_valid_i && in_ready_o;
	assign rd = out_ready_i && out_valid_o;

	// storage
	always_ff @(posedge clk_i)
	begin
		if (wr)
			mem[wp_q] <= in_data_i;
	end

	// pointers and fill level; flush empties without touching storage
	always_ff @(posedge clk_i)
	begin
		if (rst_i || flush_i)
		begin
			wp_q <= '0;
			rp_q <= '0;
			count_o <= '0;
		end
		else
		begin
			wp_q <= PW'(wp_q + PW'(wr));
			rp_q <= PW'(rp_q + PW'(rd));
			count_o <= CW'(count_o + CW'(wr) - CW'(rd));
		end
	end
endmodule

// ==== verilog/sxt_baud.sv ====
// baud tick generator at sixteen ticks per bit
`timescale 1ns/10ps
module sxt_baud (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	// divisor and tick
	input wire logic [15:0] div_i,
	output logic tick_o
);
	logic [15:0] cnt_q;

	// one tick every div+1 clocks, so a bit of 16 ticks lasts 16*(div+1)
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clr_i)
		begin
			cnt_q <= 16'h0000;
			tick_o <= 1'h0;
		end
		else if (cnt_q == div_i)
		begin
			cnt_q <= 16'h0000;
			tick_o <= 1'h1;
		end
		else
		begin
			cnt_q <= 16'(cnt_q + 16'h0001);
			tick_o <= 1'h0;
		end
	end
endmodule

// ==== verification/sxt_remote.sv ====
// remote serial node: frames characters onto the line and decodes what the block sends
`timescale 1ns/10ps
module sxt_remote (
	// clock and line setup
	input wire logic clk_i,
	input wire logic [1:0] fmt_i,
	input wire logic two_stop_i,
	input wire logic [31:0] bit_clks_i,
	// serial link
	input wire logic line_in_i,
	output logic line_out_o
);
	// ****************************************
	// framing and decoding
	// ****************************************
	logic [8:0] got_q[$];
	int stop_bad = 0;
	// line rests high between frames, as the pull-up holds it
	initial line_out_o = 1'h1;
	// even parity for format 1, odd for format 2
	function automatic logic par_of(input logic [8:0] d);
		return (fmt_i == 2'h2) ^ (^d[7:0]);
	endfunction
	task automatic hold(input logic v, input int n);
		line_out_o <= v;
		repeat (n * int'(bit_clks_i)) @(posedge clk_i);
	endtask
	// start, data lsb first, parity, stops; faults only when asked
	task automatic send(input logic [8:0] d, input logic flip_par, input logic bad_stop);
		int nb;
		nb = (fmt_i == 2'h3) ? 9 : 8;
		hold(1'h0, 1);
		for (int i = 0; i < nb; i++) hold(d[i], 1);
		if (fmt_i == 2'h1 || fmt_i == 2'h2) hold(par_of(d) ^ flip_par, 1);
		if (two_stop_i) hold(1'h1, 1);
		hold(!bad_stop, 1);
		hold(1'h1, 1);
	endtask
	// samples mid-bit; a wrong parity or stop level is counted
	always
	begin
		logic [8:0] v;
		int nb;
		@(negedge line_in_i);
		nb = (fmt_i == 2'h3) ? 9 : 8;
		v = '0;
		repeat (int'(bit_clks_i) / 2) @(posedge clk_i);
		for (int i = 0; i < nb; i++)
		begin
			repeat (int'(bit_clks_i)) @(posedge clk_i);
			v[i] = line_in_i;
		end
		if (fmt_i == 2'h1 || fmt_i == 2'h2)
		begin
			repeat (int'(bit_clks_i)) @(posedge clk_i);
			if (line_in_i !== par_of(v)) stop_bad++;
		end
		repeat (two_stop_i ? 2 : 1)
		begin
			repeat (int'(bit_clks_i)) @(posedge clk_i);
			if (line_in_i !== 1'h1) stop_bad++;
		end
		got_q.push_back(v);
	end
endmodule

// ==== verification/sxt_uart_test.sv ====
// self-checking bench for the serial transceiver
`timescale 1ns/10ps
module sxt_uart_test;
	import sxt_pkg::*;
	// ****************************************
	// stimulus and helpers
	// ****************************************
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic [15:0] mode = 16'h0000;
	logic [15:0] div = 16'h0000;
	logic gate = 1'h0;
	logic [8:0] txd = 9'h000;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic pin_low = 1'h0;
	logic txim = 1'h0;
	logic addr_detect_on = 1'h0;
	logic [1:0] rxim = 2'h0;
	logic [8:0] rxd;
	logic [15:0] sta;
	logic txirq, rxirq, sin, sout, rline;
	logic [31:0] bclk;
	int n_errors = 0;
	int samples_checked = 0;
	int n_txirq = 0;
	int n_rxirq = 0;
	// 100 ns period
	always #50 clk_i = ~clk_i;
	assign bclk = 32'h10 * (32'(div) + 32'h1);
	// holding the pin low proves loopback ignores it
	assign sin = pin_low ? 1'h0 : rline;
	always @(posedge clk_i) if (txirq === 1'h1) n_txirq++;
	always @(posedge clk_i) if (rxirq === 1'h1) n_rxirq++;
	// break send and overrun clear stay at rest
	sxt_uart dut_u (.clk_i(clk_i), .rst_i(rst_i), .serial_mode_i(mode), .baud_divisor_i(div),
		.tx_gate_i(gate), .tx_irq_mode_i(txim), .tx_break_send_i(1'h0), .addr_detect_on_i(addr_detect_on),
		.rx_irq_mode_i(rxim), .tx_data_i(txd), .tx_write_i(wr), .rx_read_i(rd), .overrun_clr_i(1'h0),
		.rx_data_o(rxd), .serial_status_o(sta), .tx_irq_o(txirq), .rx_irq_o(rxirq),
		.serial_in_pin_i(sin), .serial_out_pin_o(sout));
	sxt_remote remote_u (.clk_i(clk_i), .fmt_i(mode[2:1]), .two_stop_i(mode[0]), .bit_clks_i(bclk),
		.line_in_i(sout), .line_out_o(rline));
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic set_mode(input logic [15:0] m);
		@(posedge clk_i);
		mode <= m;
		tick(2);
	endtask
	// one word per high cycle; a gap edge keeps the strobe single-driven
	task automatic wr_word(input logic [8:0] d);
		@(posedge clk_i);
		txd <= d;
		wr <= 1'h1;
		@(posedge clk_i);
		wr <= 1'h0;
	endtask
	task automatic fall_in(input int lim, output int c);
		c = 0;
		while (sout === 1'h1 && c < lim + 10)
		begin
			@(posedge clk_i);
			c++;
		end
	endtask
	task automatic wait_got(input int n);
		int k;
		k = 0;
		while (remote_u.got_q.size() < n && k < 20000)
		begin
			@(posedge clk_i);
			k++;
		end
		check({15'h0, remote_u.got_q.size() >= n}, 16'h1, "no frame");
	endtask
	// head char and its flags, then pop it
	task automatic rx_take(input logic [8:0] e, input logic [1:0] fl);
		int k;
		k = 0;
		while (sta[ST_AVAIL] !== 1'h1 && k < 20000)
		begin
			@(posedge clk_i);
			k++;
		end
		tick(2);
		check({7'h0, rxd}, {7'h0, e}, "rx char");
		check({14'h0, sta[ST_PARITY_FAULT:ST_FRAMING_FAULT]}, {14'h0, fl}, "rx flags");
		rd <= 1'h1;
		@(posedge clk_i);
		rd <= 1'h0;
		tick(3);
	endtask
	// ****************************************
	// test sequence
	// ****************************************
	initial
	begin
		int c;
		int k;
		logic [8:0] d;
		tick(12);
		rst_i <= 1'h0;
		tick(2);
		check(sta, 16'h0110, "reset status");
		set_mode(16'h8000);
		check({15'h0, sout}, 16'h1, "idle line");
		$display("test reset done");
		wr_word(9'h0A5);
		tick(40);
		check({15'h0, sout}, 16'h1, "gated line");
		gate <= 1'h1;
		fall_in(8, c);
		check({15'h0, c < 9}, 16'h1, "gate start");
		wait_got(1);
		check({7'h0, remote_u.got_q.pop_front()}, 16'h00A5, "tx byte");
		check(16'(n_txirq), 16'h1, "tx irq");
		wr_word(9'h13C);
		fall_in(int'(bclk) + 4, c);
		check({15'h0, c < int'(bclk) + 5}, 16'h1, "tx latency");
		wait_got(1);
		check({7'h0, remote_u.got_q.pop_front()}, 16'h003C, "bit8 dropped");
		// end-of-transmission irq: two queued words give a single pulse
		tick(20);
		txim <= 1'h1;
		k = n_txirq;
		wr_word(9'h011);
		wr_word(9'h022);
		wait_got(2);
		tick(20);
		check(16'(n_txirq - k), 16'h1, "tx irq end");
		for (int i = 1; i < 3; i++) check({7'h0, remote_u.got_q.pop_front()}, 16'h0011 * 16'(i), "pair");
		txim <= 1'h0;
		$display("test transmit done");
		// closed gate: four words fit, the fifth is dropped
		gate <= 1'h0;
		set_mode(16'h8007);
		for (int i = 1; i < 6; i++) wr_word(9'h100 + 9'(i));
		tick(3);
		check({15'h0, sta[ST_FULL]}, 16'h1, "full flag");
		gate <= 1'h1;
		wait_got(4);
		tick(int'(bclk) * 16);
		check(16'(remote_u.got_q.size()), 16'h4, "fifo depth");
		for (int i = 1; i < 5; i++) check({7'h0, remote_u.got_q.pop_front()}, 16'h100 + 16'(i), "order");
		check(16'(remote_u.stop_bad), 16'h0, "two stops");
		$display("test fifo done");
		// every format, with and without a parity slip
		for (int f = 0; f < 8; f++)
		begin
			set_mode(16'h8000 | 16'((f >> 1) << 1));
			d = 9'h15A ^ 9'(f);
			remote_u.send(d, f[0], 1'h0);
			rx_take((f > 5) ? d : {1'h0, d[7:0]}, {f[0] && (f > 1) && (f < 6), 1'h0});
		end
		set_mode(16'h8001);
		fork
			remote_u.send(9'h033, 1'h0, 1'h1);
			begin
				tick(int'(bclk) * 3);
				check({15'h0, sta[ST_QUIET]}, 16'h0, "busy rx");
			end
		join
		rx_take(9'h033, 2'h1);
		check({15'h0, sta[ST_QUIET]}, 16'h1, "quiet rx");
		set_mode(16'h8000);
		k = n_rxirq;
		remote_u.hold(1'h0, 14);
		remote_u.hold(1'h1, 2);
		rx_take(9'h000, 2'h1);
		check(16'(n_rxirq - k), 16'h1, "break irq");
		check({15'h0, sta[ST_QUIET]}, 16'h1, "break quiet");
		check({15'h0, sta[ST_AVAIL]}, 16'h0, "one break char");
		// address words interrupt even with a level irq mode that would stay silent
		set_mode(16'h8006);
		addr_detect_on <= 1'h1;
		rxim <= 2'h2;
		k = n_rxirq;
		remote_u.send(9'h1A5, 1'h0, 1'h0);
		remote_u.send(9'h0A5, 1'h0, 1'h0);
		rx_take(9'h1A5, 2'h0);
		rx_take(9'h0A5, 2'h0);
		check(16'(n_rxirq - k), 16'h1, "addr irq");
		check({15'h0, sta[ST_ADDR]}, 16'h1, "addr flag");
		addr_detect_on <= 1'h0;
		rxim <= 2'h0;
		$display("test receive done");
		set_mode(16'h8040);
		pin_low <= 1'h1;
		wr_word(9'h096);
		rx_take(9'h096, 2'h0);
		wait_got(1);
		check({7'h0, remote_u.got_q.pop_front()}, 16'h0096, "loop pin");
		pin_low <= 1'h0;
		set_mode(16'h8000);
		$display("test loopback done");
		div <= 16'h0002;
		tick(2);
		wr_word(9'h001);
		fall_in(200, c);
		c = 0;
		while (sout === 1'h0 && c < 100)
		begin
			@(posedge clk_i);
			c++;
		end
		check(16'(c), 16'h0030, "bit length");
		wait_got(1);
		check({7'h0, remote_u.got_q.pop_front()}, 16'h0001, "slow byte");
		$display("test baud done");
		// a mid-run reset must lose queued words
		gate <= 1'h0;
		wr_word(9'h055);
		wr_word(9'h066);
		rst_i <= 1'h1;
		tick(2);
		rst_i <= 1'h0;
		tick(3);
		gate <= 1'h1;
		tick(int'(bclk) * 12);
		check(16'(remote_u.got_q.size()), 16'h0, "reset flush");
		wr_word(9'h0F0);
		wr_word(9'h00F);
		tick(int'(bclk) * 3);
		mode <= 16'h0000;
		tick(4);
		check(sta, 16'h0110, "off status");
		check({15'h0, sout}, 16'h1, "off line");
		$display("test disable done");
		conclude();
	end
	// about 6k cycles expected; cut off well beyond
	initial
	begin
		tick(90000);
		n_errors++;
		conclude();
	end
endmodule
